// [rtl/sbt_pkg.sv]
package sbt_pkg;

    // ==========================================================
    // widths and chain layout
    // ==========================================================
    localparam int SBT_IR_W = 3;
    localparam int SBT_ID_W = 32;
    localparam int SBT_BSR_LEN = 90;
    localparam int SBT_BSR_OE_BIT = 89;
    localparam int SBT_IR_CAP_W = 2;
    localparam logic [1:0] SBT_IR_CAP_PAT = 2'h1;
    localparam logic SBT_IR_CAP_MSB = 1'h0;
    localparam logic SBT_BYP_CAP = 1'h0;
    localparam logic SBT_OE_CELL_RST = 1'h1;

    // identification value is arbitrary; bit 0 kept high as usual
    localparam logic [31:0] SBT_IDCODE_DEF = 32'h0a5c_3001;

    // ==========================================================
    // instruction codes
    // ==========================================================
    localparam logic [2:0] SBT_OP_EXTEST = 3'h0;
    localparam logic [2:0] SBT_OP_IDCODE = 3'h1;
    localparam logic [2:0] SBT_OP_SAMPLE_Z = 3'h2;
    localparam logic [2:0] SBT_OP_SAMPLE = 3'h4;
    localparam logic [2:0] SBT_OP_BYPASS = 3'h7;

    // ==========================================================
    // controller states
    // ==========================================================
    typedef enum logic [15:0] {
        SBT_TLR = 16'h0001,
        SBT_RTI = 16'h0002,
        SBT_SEL_DR = 16'h0004,
        SBT_CAP_DR = 16'h0008,
        SBT_SH_DR = 16'h0010,
        SBT_EX1_DR = 16'h0020,
        SBT_PAU_DR = 16'h0040,
        SBT_EX2_DR = 16'h0080,
        SBT_UPD_DR = 16'h0100,
        SBT_SEL_IR = 16'h0200,
        SBT_CAP_IR = 16'h0400,
        SBT_SH_IR = 16'h0800,
        SBT_EX1_IR = 16'h1000,
        SBT_PAU_IR = 16'h2000,
        SBT_EX2_IR = 16'h4000,
        SBT_UPD_IR = 16'h8000
    } sbt_state_t;

endpackage

// [rtl/sbt_sync2.sv]
module sbt_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic en_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    // ==========================================================
    // two-stage synchroniser, first stage feeds only the second
    // ==========================================================
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_r <= RST_VAL;
            q_o <= RST_VAL;
        end
        else if (en_i)
        begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end

endmodule

// [rtl/sbt_tap_fsm.sv]
module sbt_tap_fsm
    import sbt_pkg::*;
(
    input wire logic tck_i,
    input wire logic rstn_i,
    input wire logic tms_i,
    output sbt_pkg::sbt_state_t state_o
);

    // ==========================================================
    // sixteen-state controller
    // ==========================================================
    sbt_state_t state_nxt;

    always_comb
    begin
        state_nxt = state_o;
        unique case (state_o)
            SBT_TLR: state_nxt = tms_i ? SBT_TLR : SBT_RTI;
            SBT_RTI: state_nxt = tms_i ? SBT_SEL_DR : SBT_RTI;
            SBT_SEL_DR: state_nxt = tms_i ? SBT_SEL_IR : SBT_CAP_DR;
            SBT_CAP_DR: state_nxt = tms_i ? SBT_EX1_DR : SBT_SH_DR;
            SBT_SH_DR: state_nxt = tms_i ? SBT_EX1_DR : SBT_SH_DR;
            SBT_EX1_DR: state_nxt = tms_i ? SBT_UPD_DR : SBT_PAU_DR;
            SBT_PAU_DR: state_nxt = tms_i ? SBT_EX2_DR : SBT_PAU_DR;
            SBT_EX2_DR: state_nxt = tms_i ? SBT_UPD_DR : SBT_SH_DR;
            SBT_UPD_DR: state_nxt = tms_i ? SBT_SEL_DR : SBT_RTI;
            SBT_SEL_IR: state_nxt = tms_i ? SBT_TLR : SBT_CAP_IR;
            SBT_CAP_IR: state_nxt = tms_i ? SBT_EX1_IR : SBT_SH_IR;
            SBT_SH_IR: state_nxt = tms_i ? SBT_EX1_IR : SBT_SH_IR;
            SBT_EX1_IR: state_nxt = tms_i ? SBT_UPD_IR : SBT_PAU_IR;
            SBT_PAU_IR: state_nxt = tms_i ? SBT_EX2_IR : SBT_PAU_IR;
            SBT_EX2_IR: state_nxt = tms_i ? SBT_UPD_IR : SBT_SH_IR;
            SBT_UPD_IR: state_nxt = tms_i ? SBT_SEL_DR : SBT_RTI;
            default: state_nxt = SBT_TLR;
        endcase
    end

    // five rising edges with tms high reach reset from any state
    always_ff @(posedge tck_i or negedge rstn_i)
    begin
        if (!rstn_i)
            state_o <= SBT_TLR;
        else
            state_o <= state_nxt;
    end

endmodule

// [rtl/sbt_tap.sv]
// Contract
// - inputs sampled on rising test clock, outputs change on falling edge.
// - test mode select sampled each rising edge steers the controller.
// - undriven test mode select reads high through the pad pull-up; this module has no pull-up, tms_i is used as driven.
// - current instruction selects the scan register on the serial path.
// - only one scan register sits on the serial path at a time.
// - serial input enters the selected register at its most significant bit.
// - serial output shows the least significant bit of the selected register.
// - serial output driven only in shift states, else high impedance.
// - controller reset never disturbs memory read or write operation.
// - controller resets itself at power-up, serial output starts undriven.
// - instruction register is three bits, shifted only while selected.
// - instruction register takes identification code at power-up and reset.
// - instruction capture loads binary 01 into the two low bits.
// - one-bit bypass register gives minimal delay through the part.
// - bypass register captures low while bypass is executed.
// - boundary register has a cell on every input and two-way pin.
// - boundary register captures ring in capture, shifts in shift state.
// - external test, sample and sample-hiz select and capture the ring.
// - identification instruction captures fixed 32-bit code.
// - identification code is hardwired and shifts out in shift state.
// - sample-hiz selects boundary register and floats all memory outputs.
// - three codes are reserved and unimplemented; tester should avoid them.
// - bypass instruction places bypass register on the path in shift.
// - output-enable cell gates bus in external test, preset high on reset.
module sbt_tap
    import sbt_pkg::*;
#(
    parameter int BSR_LEN = SBT_BSR_LEN,
    parameter int BSR_OE_BIT = SBT_BSR_OE_BIT,
    parameter logic [31:0] IDCODE_VAL = SBT_IDCODE_DEF,
    parameter logic [2:0] OP_EXTEST = SBT_OP_EXTEST,
    parameter logic [2:0] OP_IDCODE = SBT_OP_IDCODE,
    parameter logic [2:0] OP_SAMPLE_Z = SBT_OP_SAMPLE_Z,
    parameter logic [2:0] OP_SAMPLE = SBT_OP_SAMPLE,
    parameter logic [2:0] OP_BYPASS = SBT_OP_BYPASS
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    input wire logic [BSR_LEN-1:0] ring_in_i,
    output logic [BSR_LEN-1:0] ring_drive_o,
    output logic extest_o,
    output logic out_hiz_o
);
    import sbt_pkg::*;

    // ==========================================================
    // test clock domain reset
    // ==========================================================
    // power-up reset asserts at once, releases on the test clock
    logic tap_rstn;

    sbt_sync2 #(
        .W(1),
        .RST_VAL(1'h0)
    ) u_rst_sync (
        .clk_i(tck_i),
        .rstn_i(rstn_i),
        .en_i(1'h1),
        .d_i(1'h1),
        .q_o(tap_rstn)
    );

    // ==========================================================
    // controller
    // ==========================================================
    sbt_state_t state;

    // no pull-up in this module; tms_i reaches the controller as driven
    sbt_tap_fsm u_fsm (
        .tck_i(tck_i),
        .rstn_i(tap_rstn),
        .tms_i(tms_i),
        .state_o(state)
    );

    logic in_tlr;
    logic cap_ir;
    logic sh_ir;
    logic upd_ir;
    logic cap_dr;
    logic sh_dr;
    logic upd_dr;

    assign in_tlr = (state == SBT_TLR);
    assign cap_ir = (state == SBT_CAP_IR);
    assign sh_ir = (state == SBT_SH_IR);
    assign upd_ir = (state == SBT_UPD_IR);
    assign cap_dr = (state == SBT_CAP_DR);
    assign sh_dr = (state == SBT_SH_DR);
    assign upd_dr = (state == SBT_UPD_DR);

    // ==========================================================
    // instruction register
    // ==========================================================
    logic [SBT_IR_W-1:0] ir_sh_r;
    logic [SBT_IR_W-1:0] ir_r;

    always_ff @(posedge tck_i or negedge tap_rstn)
    begin
        if (!tap_rstn)
            ir_sh_r <= OP_IDCODE;
        else if (cap_ir)
            ir_sh_r <= {SBT_IR_CAP_MSB, SBT_IR_CAP_PAT};
        else if (sh_ir)
            ir_sh_r <= {tdi_i, ir_sh_r[SBT_IR_W-1:1]};
    end

    // active instruction changes on the falling edge
    always_ff @(negedge tck_i or negedge tap_rstn)
    begin
        if (!tap_rstn)
            ir_r <= OP_IDCODE;
        else if (in_tlr)
            ir_r <= OP_IDCODE;
        else if (upd_ir)
            ir_r <= ir_sh_r;
    end

    // ==========================================================
    // instruction decode
    // ==========================================================
    typedef enum logic [2:0] {
        SBT_SEL_BYP = 3'h1,
        SBT_SEL_ID = 3'h2,
        SBT_SEL_BSR = 3'h4
    } sbt_dr_sel_t;

    sbt_dr_sel_t dr_sel;
    logic is_extest;
    logic is_samplez;

    assign is_extest = (ir_r == OP_EXTEST);
    assign is_samplez = (ir_r == OP_SAMPLE_Z);

    // reserved codes fall back to bypass so the chain stays intact
    always_comb
    begin
        if (is_extest || is_samplez || ir_r == OP_SAMPLE)
            dr_sel = SBT_SEL_BSR;
        else if (ir_r == OP_IDCODE)
            dr_sel = SBT_SEL_ID;
        else
            dr_sel = SBT_SEL_BYP;
    end

    // ==========================================================
    // bypass register
    // ==========================================================
    logic byp_r;

    always_ff @(posedge tck_i or negedge tap_rstn)
    begin
        if (!tap_rstn)
            byp_r <= SBT_BYP_CAP;
        else if (dr_sel == SBT_SEL_BYP)
        begin
            if (cap_dr)
                byp_r <= SBT_BYP_CAP;
            else if (sh_dr)
                byp_r <= tdi_i;
        end
    end

    // ==========================================================
    // identification register
    // ==========================================================
    logic [SBT_ID_W-1:0] id_sh_r;

    always_ff @(posedge tck_i or negedge tap_rstn)
    begin
        if (!tap_rstn)
            id_sh_r <= IDCODE_VAL;
        else if (dr_sel == SBT_SEL_ID)
        begin
            if (cap_dr)
                id_sh_r <= IDCODE_VAL;
            else if (sh_dr)
                id_sh_r <= {tdi_i, id_sh_r[SBT_ID_W-1:1]};
        end
    end

    // ==========================================================
    // boundary register
    // ==========================================================
    // ring pins run on the memory clock; capture may still catch a
    // transition, which is harmless but not repeatable
    logic [BSR_LEN-1:0] ring_s;
    logic [BSR_LEN-1:0] bsr_sh_r;
    logic [BSR_LEN-1:0] bsr_upd_r;

    sbt_sync2 #(
        .W(BSR_LEN),
        .RST_VAL('0)
    ) u_ring_sync (
        .clk_i(tck_i),
        .rstn_i(tap_rstn),
        .en_i(1'h1),
        .d_i(ring_in_i),
        .q_o(ring_s)
    );

    always_ff @(posedge tck_i or negedge tap_rstn)
    begin
        if (!tap_rstn)
            bsr_sh_r <= '0;
        else if (dr_sel == SBT_SEL_BSR)
        begin
            if (cap_dr)
                bsr_sh_r <= ring_s;
            else if (sh_dr)
                bsr_sh_r <= {tdi_i, bsr_sh_r[BSR_LEN-1:1]};
        end
    end

    // update stage: one generate cell per bit, oe cell presets high
    genvar gi;
    generate
        for (gi = 0; gi < BSR_LEN; gi++)
        begin : g_upd
            localparam logic RV = (gi == BSR_OE_BIT) ? SBT_OE_CELL_RST : 1'h0;

            always_ff @(negedge tck_i or negedge tap_rstn)
            begin
                if (!tap_rstn)
                    bsr_upd_r[gi] <= RV;
                else if (in_tlr)
                    bsr_upd_r[gi] <= RV;
                else if (upd_dr && dr_sel == SBT_SEL_BSR)
                    bsr_upd_r[gi] <= bsr_sh_r[gi];
            end
        end
    endgenerate

    // ==========================================================
    // serial output
    // ==========================================================
    logic tdo_nxt;

    always_comb
    begin
        if (sh_ir)
            tdo_nxt = ir_sh_r[0];
        else
        begin
            unique case (dr_sel)
                SBT_SEL_ID: tdo_nxt = id_sh_r[0];
                SBT_SEL_BSR: tdo_nxt = bsr_sh_r[0];
                default: tdo_nxt = byp_r;
            endcase
        end
    end

    always_ff @(negedge tck_i or negedge tap_rstn)
    begin
        if (!tap_rstn)
        begin
            tdo_o <= 1'h0;
            tdo_oe_o <= 1'h0;
        end
        else
        begin
            tdo_o <= tdo_nxt;
            tdo_oe_o <= sh_ir | sh_dr;
        end
    end

    // ==========================================================
    // memory-side controls
    // ==========================================================
    // registered before crossing so no decode glitch reaches the core
    logic extest_r;
    logic samplez_r;

    always_ff @(negedge tck_i or negedge tap_rstn)
    begin
        if (!tap_rstn)
        begin
            extest_r <= 1'h0;
            samplez_r <= 1'h0;
        end
        else
        begin
            extest_r <= is_extest;
            samplez_r <= is_samplez;
        end
    end

    // core side only follows the controls; a controller reset just
    // returns them to idle values, memory cycles carry on
    localparam logic [BSR_LEN-1:0] UPD_RST =
        {{(BSR_LEN - 1){1'h0}}, SBT_OE_CELL_RST} << BSR_OE_BIT;
    localparam logic [BSR_LEN+1:0] CORE_RST = {2'h0, UPD_RST};

    logic [BSR_LEN+1:0] core_s;
    logic [BSR_LEN+1:0] core_prev_r;
    logic core_hiz;

    sbt_sync2 #(
        .W(BSR_LEN + 2),
        .RST_VAL(CORE_RST)
    ) u_core_sync (
        .clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .en_i(clk_en_i),
        .d_i({samplez_r, extest_r, bsr_upd_r}),
        .q_o(core_s)
    );

    // gate worked out from one word, so the bus is never live for a
    // moment while the enable cell is already low
    assign core_hiz = core_s[BSR_LEN+1] | (core_s[BSR_LEN] & ~core_s[BSR_OE_BIT]);

    // bits of the word may land one memory clock apart; a word is only
    // taken once two samples agree, so outputs never show a mixed word
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            core_prev_r <= CORE_RST;
        else if (clk_en_i)
            core_prev_r <= core_s;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ring_drive_o <= UPD_RST;
            extest_o <= 1'h0;
            out_hiz_o <= 1'h0;
        end
        else if (clk_en_i && core_s == core_prev_r)
        begin
            ring_drive_o <= core_s[BSR_LEN-1:0];
            extest_o <= core_s[BSR_LEN];
            out_hiz_o <= core_hiz;
        end
    end

endmodule

// [dv/sbt_tap_sva.sv]
module sbt_tap_chk #(
    parameter int BSR_LEN = 90,
    parameter int BSR_OE_BIT = 89
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic clk_en_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic [BSR_LEN-1:0] ring_drive_o,
    input wire logic extest_o,
    input wire logic out_hiz_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ====================================
    // assertions
    // ====================================
    tdo_fall_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $changed(tdo_o) |-> !tck_i) else $error("serial out moved while tck high");
    oe_fall_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $changed(tdo_oe_o) |-> !tck_i) else $error("out enable moved while tck high");
    oe_start_a: assert property (@(posedge tck_i) disable iff (!rstn_i)
        $rose(tdo_oe_o) |-> !$past(tms_i)) else $error("out enable rose without shift entry");
    oe_stop_a: assert property (@(posedge tck_i) disable iff (!rstn_i)
        tdo_oe_o && tms_i |=> !tdo_oe_o) else $error("out enable held after shift exit");
    oe_hold_a: assert property (@(posedge tck_i) disable iff (!rstn_i)
        tdo_oe_o && !tms_i |=> tdo_oe_o) else $error("out enable dropped mid shift");
    tap_reset_a: assert property (@(posedge tck_i) disable iff (!rstn_i)
        (tms_i && clk_en_i) [*5] |-> ##2 (!extest_o && !out_hiz_o && ring_drive_o[BSR_OE_BIT]))
        else $error("five high mode selects did not reset");
    oe_cell_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        (extest_o && !ring_drive_o[BSR_OE_BIT]) [*3] |-> out_hiz_o)
        else $error("output bus not floated by low enable cell");
    power_up_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
        $rose(rstn_i) |-> ring_drive_o[BSR_OE_BIT] && !extest_o && !out_hiz_o && !tdo_oe_o)
        else $error("wrong state after power-up");

    // ====================================
    // covers
    // ====================================
    cover property (@(posedge tck_i) $rose(tdo_oe_o));
    cover property (@(posedge core_clk_i) $rose(extest_o));
    cover property (@(posedge core_clk_i) $rose(out_hiz_o));
endmodule

bind sbt_tap sbt_tap_chk #(.BSR_LEN(BSR_LEN), .BSR_OE_BIT(BSR_OE_BIT)) u_chk (
    .core_clk_i, .rstn_i, .clk_en_i, .tck_i, .tms_i, .tdo_o, .tdo_oe_o,
    .ring_drive_o, .extest_o, .out_hiz_o
);

// [dv/sbt_jtag_host.sv]
module sbt_jtag_host (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;

    // ====================================
    // board tester, tck stands low between frames
    // ====================================
    // idle lines sit at the pull-up level
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // one 30 ns tck period; out is read at the rise, as the device drove it at the fall
    task automatic tick(input logic tms_v, input logic tdi_v, output logic tdo_v);
        tms_o = tms_v;
        tdi_o = tdi_v;
        #15;
        tck_o = 1'b1;
        tdo_v = tdo_oe_i ? tdo_i : 1'bz;
        #15;
        tck_o = 1'b0;
    endtask

    task automatic reset5();
        logic d;
        repeat (5) tick(1'b1, 1'b1, d);
        tick(1'b0, 1'b1, d);
    endtask

    // from idle: scan n bits of the instruction or data path, back to idle
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic d;
        dout = '0;
        tick(1'b1, 1'b1, d);
        if (ir)
            tick(1'b1, 1'b1, d);
        tick(1'b0, 1'b1, d);
        tick(1'b0, 1'b1, d);
        for (int i = 0; i < n; i++)
        begin
            tick(i == n - 1, din[i], d);
            dout[i] = d;
        end
        tick(1'b1, 1'b1, d);
        tick(1'b0, 1'b1, d);
    endtask
endmodule

// [dv/test_sbt_tap.sv]
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, got, exp); end end

module test_sbt_tap;
    timeunit 1ns;
    timeprecision 100ps;
    import sbt_pkg::*;

    localparam logic [SBT_BSR_LEN-1:0] RING = 90'h3_0123_4567_89ab_cdef_7777;
    // enable cell bit is low in this pattern
    localparam logic [SBT_BSR_LEN-1:0] PAT = 90'h0_3c3c_a5a5_5a5a_c3c3_0ff0;

    logic core_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic [SBT_BSR_LEN-1:0] ring_in_i = '0;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic extest;
    logic out_hiz;
    logic [SBT_BSR_LEN-1:0] ring_drive;
    logic [127:0] dout;
    int n_errors = 0;
    int tests_run = 0;

    always #2 core_clk_i = ~core_clk_i;

    sbt_tap u_dut (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .clk_en_i(clk_en_i),
        .tck_i(tck),
        .tms_i(tms),
        .tdi_i(tdi),
        .tdo_o(tdo),
        .tdo_oe_o(tdo_oe),
        .ring_in_i(ring_in_i),
        .ring_drive_o(ring_drive),
        .extest_o(extest),
        .out_hiz_o(out_hiz)
    );

    sbt_jtag_host u_host (
        .tck_o(tck),
        .tms_o(tms),
        .tdi_o(tdi),
        .tdo_i(tdo),
        .tdo_oe_i(tdo_oe)
    );

    // ====================================
    // scenarios
    // ====================================
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic load_ir(input logic [2:0] op);
        u_host.scan(1'b1, 3, {125'h0, op}, dout);
        `CHK(dout[2:0], {SBT_IR_CAP_MSB, SBT_IR_CAP_PAT})
    endtask

    task automatic t_power_up();
        `CHK({tdo_oe, extest, out_hiz}, 3'h0)
        `CHK(ring_drive[SBT_BSR_OE_BIT], 1'h1)
        u_host.reset5();
        u_host.scan(1'b0, 32, '0, dout);
        `CHK(dout[31:0], SBT_IDCODE_DEF)
        $display("power-up test done");
    endtask

    // reserved codes must behave like the one-bit path
    task automatic t_bypass();
        logic [2:0] ops [4] = '{SBT_OP_BYPASS, 3'h3, 3'h5, 3'h6};
        foreach (ops[k])
        begin
            load_ir(ops[k]);
            u_host.scan(1'b0, 3, 128'h5, dout);
            `CHK(dout[2:0], 3'h2)
        end
        $display("bypass test done");
    endtask

    task automatic t_boundary();
        logic [2:0] ops [4] = '{SBT_OP_SAMPLE, SBT_OP_SAMPLE_Z, SBT_OP_EXTEST, SBT_OP_EXTEST};
        logic [SBT_BSR_LEN-1:0] din;
        @(posedge core_clk_i) ring_in_i <= RING;
        foreach (ops[k])
        begin
            din = k[0] ? ~PAT : PAT;
            load_ir(ops[k]);
            u_host.scan(1'b0, SBT_BSR_LEN, 128'(din), dout);
            `CHK(dout[SBT_BSR_LEN-1:0], RING)
            repeat (6) @(posedge core_clk_i);
            `CHK(ring_drive, din)
            `CHK(extest, ops[k] == SBT_OP_EXTEST)
            `CHK(out_hiz, ops[k] == SBT_OP_SAMPLE_Z || (ops[k] == SBT_OP_EXTEST && !din[SBT_BSR_OE_BIT]))
        end
        $display("boundary test done");
    endtask

    // memory clock stalled across the reset, then released
    task automatic t_tap_reset();
        @(posedge core_clk_i) clk_en_i <= 1'b0;
        u_host.reset5();
        repeat (6) @(posedge core_clk_i);
        `CHK({extest, ring_drive[SBT_BSR_OE_BIT]}, 2'h3)
        @(posedge core_clk_i) clk_en_i <= 1'b1;
        repeat (6) @(posedge core_clk_i);
        `CHK({extest, out_hiz, ring_drive[SBT_BSR_OE_BIT]}, 3'h1)
        u_host.scan(1'b0, 32, '0, dout);
        `CHK(dout[31:0], SBT_IDCODE_DEF)
        $display("tap reset test done");
    endtask

    // ====================================
    // stimulus
    // ====================================
    initial
    begin
        repeat (10) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        // keeps tck edges off the memory clock edges
        #1.3;
        t_power_up();
        t_bypass();
        t_boundary();
        t_tap_reset();
        complete_run();
    end

    // the full run needs about 17 us of tck traffic
    initial
    begin
        #200000;
        n_errors++;
        complete_run();
    end
endmodule
